/* File: design/hcib_pkg.sv */
// Package with register layout and constants for host/core interrupt bits
package hcib_pkg;
    localparam int unsigned HCIB_AW = 4;
    localparam int unsigned HCIB_DW = 8;
    // Register offsets
    localparam logic [3:0] HCIB_OFS_HOST_CTRL = 4'h0;
    localparam logic [3:0] HCIB_OFS_CORE_REG = 4'h1;
    localparam logic [3:0] HCIB_OFS_IRQ_STATUS = 4'h2;
    localparam logic [3:0] HCIB_OFS_IRQ_MASK = 4'h3;
    // Host interrupt control field positions
    localparam int unsigned HCIB_BIT_DA_STATUS = 0;
    localparam int unsigned HCIB_BIT_CORE_IRQ_EN = 1;
    localparam int unsigned HCIB_BIT_H2C_REQ = 2;
    localparam int unsigned HCIB_BIT_HOST_IRQ = 3;
    localparam int unsigned HCIB_BIT_WAIT_MODE = 4;
    // Core register field positions
    localparam int unsigned HCIB_BIT_CORE_FW_IRQ = 2;
    localparam int unsigned HCIB_BIT_CORE_H2C_CLR = 3;
    localparam int unsigned HCIB_BIT_CORE_GRANT = 7;
    // Event status bit positions
    localparam int unsigned HCIB_EV_HOST_IRQ = 0;
    localparam int unsigned HCIB_EV_H2C = 1;
    localparam int unsigned HCIB_EV_GRANT = 2;
    localparam int unsigned HCIB_EV_W = 3;
    localparam logic [7:0] HCIB_RST_BYTE = 8'h00;
endpackage

/* File: design/hcib_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module hcib_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous input and filtered level
    input wire logic async_in,
    output logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change counts only once stages two and three agree
            if (agree) begin
                lvl_q <= s3_q;
            end
        end
    end

    assign level_out = lvl_q;
endmodule
`default_nettype wire

/* File: design/hcib_sticky.sv */
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module hcib_sticky #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Set pulses and clear mask
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_q;
    // Set wins so an event in the clearing cycle is kept
    wire [W-1:0] flags_d = set_in | (flags_q & ~clr_in);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
endmodule
`default_nettype wire

/* File: design/hcib_top.sv */
// Host/core interrupt and handshake bits with register port
//
// Contract
// - Wait-mode 0 routes firmware flag to host irq; 1 routes transceiver irq.
// - Selected source raising an interrupt sets host irq flag bit 3.
// - Host irq flag stays set until host writes one to it.
// - Host setting request bit 2 asserts interrupt to the core.
// - Request bit stays set until core writes one to its bit 3.
// - Host writing zero to request bit does not change it.
// - Core irq enable bit 1 gates core interrupts to flag and pin.
// - Direct-access status bit 0 is read-only; host writes ignored.
// - Direct-access status always equals core grant bit 7.
// - While grant set, host side gets direct memory access.
// - Firmware should halt after granting direct access to avoid collisions.
// - Wait-mode bit 4 holds core ready low and enters direct access.
`timescale 1ns/1ps
`default_nettype none
module hcib_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core register port
    input wire logic [7:0] core_wdata,
    input wire logic core_wr,
    output logic [7:0] core_rdata,
    // Transceiver interrupt from pin
    input wire logic transceiver_interface_irq,
    // Core side outputs
    output logic core_irq,
    output logic core_ready,
    // Host side outputs
    output logic host_irq_pin,
    output logic direct_access_mode,
    output logic event_irq
);
    localparam int unsigned EW = hcib_pkg::HCIB_EV_W;

    // Host-side control bits
    logic wait_mode_q;
    logic core_irq_enable_q;
    logic h2c_req_q;
    logic host_irq_flag_q;
    // Core-side bits
    logic fw_irq_q;
    logic grant_q;
    // Source edge detect
    logic src_prev_q;
    // Event mask
    logic [EW-1:0] ev_mask_q;
    // Output registers
    logic [7:0] rdata_q;
    logic [7:0] core_rdata_q;
    logic core_irq_q;
    logic core_ready_q;
    logic host_pin_q;
    logic dam_q;
    logic event_irq_q;

    // Synchronised transceiver interrupt
    logic tai_lvl;
    hcib_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(transceiver_interface_irq),
        .level_out(tai_lvl)
    );

    // Address decode
    wire sel_ctrl = (reg_addr == hcib_pkg::HCIB_OFS_HOST_CTRL);
    wire sel_core = (reg_addr == hcib_pkg::HCIB_OFS_CORE_REG);
    wire sel_stat = (reg_addr == hcib_pkg::HCIB_OFS_IRQ_STATUS);
    wire sel_mask = (reg_addr == hcib_pkg::HCIB_OFS_IRQ_MASK);
    wire wr_ctrl = reg_wr & sel_ctrl;
    wire wr_stat = reg_wr & sel_stat;
    wire wr_mask = reg_wr & sel_mask;

    // Interrupt source selection
    wire src_sel = wait_mode_q ? tai_lvl : fw_irq_q;
    // Core-originated interrupts only pass when enabled; transceiver not gated
    wire src_gated = wait_mode_q ? src_sel : (src_sel & core_irq_enable_q);
    wire src_rise = src_gated & ~src_prev_q;

    // Host irq flag: set wins over write-one clear
    wire host_clr = wr_ctrl & reg_wdata[hcib_pkg::HCIB_BIT_HOST_IRQ];
    wire host_flag_d = src_rise | (host_irq_flag_q & ~host_clr);

    // Request to core: host sets, core clears via write-one
    wire h2c_set = wr_ctrl & reg_wdata[hcib_pkg::HCIB_BIT_H2C_REQ];
    wire h2c_clr = core_wr & core_wdata[hcib_pkg::HCIB_BIT_CORE_H2C_CLR];
    wire h2c_d = h2c_set | (h2c_req_q & ~h2c_clr);

    // Grant rising edge counts as an event
    wire grant_d = core_wr ? core_wdata[hcib_pkg::HCIB_BIT_CORE_GRANT] : grant_q;
    wire fw_irq_d = core_wr ? core_wdata[hcib_pkg::HCIB_BIT_CORE_FW_IRQ] : fw_irq_q;

    // Host-visible control byte; bit 0 mirrors grant and ignores writes
    wire [7:0] ctrl_byte = {3'b000, wait_mode_q, host_irq_flag_q, h2c_req_q,
                            core_irq_enable_q, grant_q};
    wire [7:0] core_byte = {grant_q, 3'b000, h2c_req_q, fw_irq_q, 2'b00};

    // Event flags
    logic [EW-1:0] ev_flags;
    logic [EW-1:0] ev_set;
    assign ev_set[hcib_pkg::HCIB_EV_HOST_IRQ] = src_rise;
    assign ev_set[hcib_pkg::HCIB_EV_H2C] = h2c_set & ~h2c_req_q;
    assign ev_set[hcib_pkg::HCIB_EV_GRANT] = grant_d & ~grant_q;
    wire [EW-1:0] ev_clr = wr_stat ? reg_wdata[EW-1:0] : '0;

    hcib_sticky #(
        .W(EW)
    ) u_sticky (
        .clk(clk),
        .nrst(nrst),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .flags(ev_flags)
    );

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_mux = sel_ctrl ? ctrl_byte :
                        sel_core ? core_byte :
                        sel_stat ? {{(8 - EW){1'b0}}, ev_flags} :
                        sel_mask ? {{(8 - EW){1'b0}}, ev_mask_q} :
                        hcib_pkg::HCIB_RST_BYTE;

    // Control bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_mode_q <= 1'b0;
            core_irq_enable_q <= 1'b0;
            h2c_req_q <= 1'b0;
            host_irq_flag_q <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                wait_mode_q <= reg_wdata[hcib_pkg::HCIB_BIT_WAIT_MODE];
                core_irq_enable_q <= reg_wdata[hcib_pkg::HCIB_BIT_CORE_IRQ_EN];
            end
            h2c_req_q <= h2c_d;
            host_irq_flag_q <= host_flag_d;
            src_prev_q <= src_gated;
        end
    end

    // Core-side register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            grant_q <= 1'b0;
            fw_irq_q <= 1'b0;
        end else begin
            grant_q <= grant_d;
            fw_irq_q <= fw_irq_d;
        end
    end

    // Event mask
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev_mask_q <= '0;
        end else if (wr_mask) begin
            ev_mask_q <= reg_wdata[EW-1:0];
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= hcib_pkg::HCIB_RST_BYTE;
            core_rdata_q <= hcib_pkg::HCIB_RST_BYTE;
            core_irq_q <= 1'b0;
            core_ready_q <= 1'b1;
            host_pin_q <= 1'b0;
            dam_q <= 1'b0;
            event_irq_q <= 1'b0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : hcib_pkg::HCIB_RST_BYTE;
            core_rdata_q <= core_byte;
            // Request also wakes a halted core to drop the grant
            core_irq_q <= h2c_d;
            core_ready_q <= ~wait_mode_q;
            host_pin_q <= host_flag_d;
            // Grant or wait mode opens host path to local memory
            dam_q <= grant_d | wait_mode_q;
            event_irq_q <= |(ev_flags & ev_mask_q);
        end
    end

    assign reg_rdata = rdata_q;
    assign core_rdata = core_rdata_q;
    assign core_irq = core_irq_q;
    assign core_ready = core_ready_q;
    assign host_irq_pin = host_pin_q;
    assign direct_access_mode = dam_q;
    assign event_irq = event_irq_q;
endmodule
`default_nettype wire

/* File: dv/hcib_asserts.sv */
// Checker for host and core interrupt bits
`timescale 1ns/1ps
`default_nettype none
module hcib_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Core port
    input wire logic [7:0] core_wdata,
    input wire logic core_wr,
    input wire logic core_irq,
    input wire logic core_ready,
    // Host side
    input wire logic host_irq_pin,
    input wire logic direct_access_mode
);
    wire logic cw = reg_wr && reg_addr == 4'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Ready trails the wait bit by one more flop
    a_wait_ready: assert property (cw |=> ##1 core_ready == !$past(reg_wdata[4], 2))
        else $error("ready not following wait mode");
    a_req_set: assert property (cw && reg_wdata[2] |=> core_irq)
        else $error("request did not raise core irq");
    a_req_hold: assert property (core_irq && !(core_wr && core_wdata[3]) |=> core_irq)
        else $error("request dropped without core clear");
    a_req_clear: assert property (core_irq && core_wr && core_wdata[3] && !cw |=> !core_irq)
        else $error("core clear ignored");
    a_flag_hold: assert property (host_irq_pin && !(cw && reg_wdata[3]) |=> host_irq_pin)
        else $error("host flag dropped");
    // Ready lags wait mode, so a control write one cycle back is excluded
    a_grant_mirror: assert property (core_wr && core_ready && !cw && !$past(cw)
        |=> direct_access_mode == $past(core_wdata[7]))
        else $error("direct access not equal grant");
    a_status_ro: assert property (cw && core_ready && !reg_wdata[4] && !core_wr
        && !$past(cw) |=> $stable(direct_access_mode))
        else $error("host write moved direct access");
    a_read_ctrl: assert property (reg_rd && reg_addr == 4'h0 && !$past(cw) |=>
        reg_rdata[4:2] == {!$past(core_ready), $past(host_irq_pin), $past(core_irq)})
        else $error("control read mismatch");
    c_flag: cover property ($rose(host_irq_pin));
    c_req: cover property ($fell(core_irq));
    c_dam: cover property ($rose(direct_access_mode));
    c_wait: cover property ($fell(core_ready));
endmodule
bind hcib_top hcib_asserts u_asserts (
    .clk(clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .core_wdata(core_wdata),
    .core_wr(core_wr),
    .core_irq(core_irq),
    .core_ready(core_ready),
    .host_irq_pin(host_irq_pin),
    .direct_access_mode(direct_access_mode)
);
`default_nettype wire

/* File: dv/hcib_core_model.sv */
// Firmware and transceiver model on the core side
`timescale 1ns/1ps
`default_nettype none
module hcib_core_model (
    // Clock
    input wire logic clk,
    // Core side
    input wire logic core_irq,
    output logic [7:0] core_wdata,
    output logic core_wr,
    output logic xirq
);
    logic grant = 1'b0;
    int cmd_cnt = 0;
    int done_cnt = 0;
    logic [7:0] nxt = 8'h00;
    initial begin
        core_wr = 1'b0;
        core_wdata = 8'h00;
        xirq = 1'b0;
    end
    // Counters hand the command over, so each variable has one writer
    task automatic cmd(input logic [7:0] d);
        nxt <= d;
        cmd_cnt <= cmd_cnt + 1;
        repeat (2) @(posedge clk);
    endtask
    task automatic irq(input logic v);
        xirq <= v;
    endtask
    // Halted while granted, so only an interrupt wakes it to drop the grant
    always @(posedge clk) begin
        if (cmd_cnt != done_cnt) begin
            core_wdata <= nxt;
            grant <= nxt[7];
            done_cnt <= cmd_cnt;
            core_wr <= 1'b1;
        end else if (core_irq && grant) begin
            core_wdata <= 8'h08;
            grant <= 1'b0;
            core_wr <= 1'b1;
        end else begin
            core_wr <= 1'b0;
            core_wdata <= ~core_wdata;
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for host and core interrupt bits
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, nrst, reg_wr, reg_rd, core_wr, transceiver_interface_irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, core_wdata, core_rdata, d;
    logic core_irq, core_ready, host_irq_pin, direct_access_mode, event_irq;
    int num_errors = 0;
    int n_checks = 0;
    hcib_top uut (
        .clk(clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .core_wdata(core_wdata),
        .core_wr(core_wr),
        .core_rdata(core_rdata),
        .transceiver_interface_irq(transceiver_interface_irq),
        .core_irq(core_irq),
        .core_ready(core_ready),
        .host_irq_pin(host_irq_pin),
        .direct_access_mode(direct_access_mode),
        .event_irq(event_irq)
    );
    hcib_core_model fw (.clk(clk), .core_irq(core_irq), .core_wdata(core_wdata),
        .core_wr(core_wr), .xirq(transceiver_interface_irq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [7:0] ctl_exp(input logic [7:0] v);
        return v & 8'h12;
    endfunction
    function automatic logic sig(input int i);
        case (i)
            0: return core_irq;
            1: return core_ready;
            2: return host_irq_pin;
            3: return direct_access_mode;
            default: return event_irq;
        endcase
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("read", e, reg_rdata);
        @(posedge clk);
    endtask
    // Bounded wait; settled value is compared, a lapse ends the run
    task automatic wt(input int i, input logic v);
        int k;
        k = 0;
        @(negedge clk);
        while (sig(i) !== v && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk("output", {7'h00, v}, {7'h00, sig(i)});
        if (sig(i) !== v) results();
        @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(32));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(4'h0, 8'h00);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(4'h0, d & 8'hF3);
            rd(4'h0, ctl_exp(d));
            wt(1, !d[4]);
            wt(3, d[4]);
            wr(4'(4 + $urandom_range(11)), d);
            rd(4'(4 + $urandom_range(11)), 8'h00);
        end
        $display("test registers done");
        wr(4'h0, 8'h04);
        wt(0, 1'b1);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h04);
        fw.cmd(8'h08);
        wt(0, 1'b0);
        fw.cmd(8'h04);
        wt(2, 1'b0);
        fw.cmd(8'h00);
        wr(4'h0, 8'h02);
        fw.cmd(8'h04);
        wt(2, 1'b1);
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h0A);
        wr(4'h0, 8'h0A);
        wt(2, 1'b0);
        $display("test request and flag done");
        wr(4'h0, 8'h10);
        fw.cmd(8'h00);
        fw.cmd(8'h04);
        wt(2, 1'b0);
        fw.irq(1'b1);
        wt(2, 1'b1);
        wr(4'h0, 8'h18);
        fw.irq(1'b0);
        wr(4'h0, 8'h00);
        fw.cmd(8'h00);
        $display("test wait mode done");
        wr(4'h0, 8'h01);
        wt(3, 1'b0);
        fw.cmd(8'h80);
        wt(3, 1'b1);
        rd(4'h0, 8'h01);
        @(negedge clk);
        chk("core_rdata", 8'h80, core_rdata);
        @(posedge clk);
        wr(4'h0, 8'h04);
        wt(3, 1'b0);
        wt(0, 1'b0);
        $display("test direct access done");
        rd(4'h2, 8'h07);
        wr(4'h3, 8'h02);
        wt(4, 1'b1);
        wr(4'h3, 8'h00);
        wt(4, 1'b0);
        wr(4'h2, 8'h07);
        rd(4'h2, 8'h00);
        $display("test events done");
        results();
    end
endmodule
`default_nettype wire
